// File: common/ccs_pkg.sv
// Purpose: shared constants and types of the system clock source control block
// Assumes: APB with 12-bit byte address and 32-bit data, inputs synchronous to pclk
// Notes:   register offsets, field positions, source codes and startup counts
package ccs_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam int          CCS_AW           = 12;
   localparam logic [11:0] CCS_OFF_CTRL     = 12'h000;
   localparam logic [11:0] CCS_OFF_CFG      = 12'h004;
   localparam logic [11:0] CCS_OFF_BKP      = 12'h008;

   // clock control register fields
   localparam int CCS_B_INT_EN  = 0;
   localparam int CCS_B_INT_RDY = 1;
   localparam int CCS_B_EXT_EN  = 16;
   localparam int CCS_B_EXT_RDY = 17;
   localparam int CCS_B_EXT_BYP = 18;
   localparam int CCS_B_PLL_EN  = 24;
   localparam int CCS_B_PLL_RDY = 25;

   // clock configuration register fields
   localparam int CCS_F_REQ     = 0;
   localparam int CCS_F_ACT     = 2;
   localparam int CCS_B_PEND    = 4;

   // backup control register fields
   localparam int CCS_B_SEXT_EN  = 0;
   localparam int CCS_B_SEXT_RDY = 1;
   localparam int CCS_B_SEXT_BYP = 2;
   localparam int CCS_F_CAL      = 8;

   // -----------------------------------------------------------------
   // encodings and reset values
   // -----------------------------------------------------------------
   localparam logic [1:0] CCS_SRC_INT      = 2'h0;
   localparam logic [1:0] CCS_SRC_EXT      = 2'h1;
   localparam logic [1:0] CCS_SRC_PLL      = 2'h2;
   localparam logic [1:0] CCS_SRC_FAB      = 2'h3;
   localparam logic [1:0] CCS_CAL_SLOW_INT = 2'h0;
   localparam logic [1:0] CCS_CAL_SLOW_EXT = 2'h1;
   localparam logic       CCS_RST_INT_EN   = 1'b1;

   // divider ratio in internal clock rises, startup counts in pclk cycles
   localparam int CCS_SLOW_DIV    = 256;
   localparam int CCS_INT_START   = 16;
   localparam int CCS_EXT_START   = 2048;
   localparam int CCS_SEXT_START  = 4000;

   typedef enum logic [1:0] {
      CCS_SW_IDLE,
      CCS_SW_WAIT_RDY,
      CCS_SW_WAIT_LOW
   } ccs_sw_t;

   // byte-lane merge for apb writes
   function automatic logic [31:0] ccs_merge(input logic [31:0] old_v,
                                             input logic [31:0] wr_v,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = wr_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

endpackage

// File: logic/ccs_osc_ready.sv
// Purpose: startup timer that raises a ready flag once an oscillator is stable
// Assumes: enable is a registered level in the pclk domain
// Notes:   clearing enable drops ready on the next pclk edge and restarts the count
`timescale 1ns/1ps
module ccs_osc_ready #(
   parameter int STARTUP_CYCLES = 16
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic enable,
   output logic      ready
);
   localparam int CW = $clog2(STARTUP_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(STARTUP_CYCLES - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          rdy;
   } ccs_rdy_st_t;

   ccs_rdy_st_t q;
   ccs_rdy_st_t next_q;

   // count enabled cycles; ready stays until enable falls
   always_comb begin
      next_q = q;
      if (!enable) begin
         next_q.cnt = '0;
         next_q.rdy = 1'b0;
      end else if (q.cnt == LAST) begin
         next_q.rdy = 1'b1;
      end else begin
         next_q.cnt = q.cnt + CW'(1);
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign ready = q.rdy;
endmodule // ccs_osc_ready

// File: logic/ccs_clk_div.sv
// Purpose: divides a sampled clock level by an even ratio
// Assumes: clk_level is a pclk-sampled copy of a slower clock
// Notes:   counts rising edges of the level, toggles every half ratio
`timescale 1ns/1ps
module ccs_clk_div #(
   parameter int DIV = 256
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic run,
   input  wire logic clk_level,
   output logic      div_clk
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] HALF_LAST = CW'(DIV / 2 - 1);

   typedef struct packed {
      logic          prev;
      logic [CW-1:0] cnt;
      logic          out;
   } ccs_div_st_t;

   ccs_div_st_t q;
   ccs_div_st_t next_q;

   // edge count; no stop input, so it keeps going in stop mode
   always_comb begin
      next_q = q;
      next_q.prev = clk_level;
      if (!run) begin
         next_q.cnt = '0;
         next_q.out = 1'b0;
      end else if (clk_level & ~q.prev) begin
         if (q.cnt == HALF_LAST) begin
            next_q.cnt = '0;
            next_q.out = ~q.out;
         end else begin
            next_q.cnt = q.cnt + CW'(1);
         end
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign div_clk = q.out;
endmodule // ccs_clk_div

// File: logic/ccs_clock_ctrl.sv
// Purpose: clock source enables, ready flags and glitch-free system clock select
// Assumes: oscillator clocks arrive as levels sampled on pclk, much slower than pclk
// Notes:   apb slave with registered answer, one wait-free access phase
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module ccs_clock_ctrl #(
   parameter int INT_START  = ccs_pkg::CCS_INT_START,
   parameter int EXT_START  = ccs_pkg::CCS_EXT_START,
   parameter int SEXT_START = ccs_pkg::CCS_SEXT_START,
   parameter int SLOW_DIV   = ccs_pkg::CCS_SLOW_DIV
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        int_fast_clk_in,
   input  wire logic        ext_fast_clk_in,
   input  wire logic        pll_clk_in,
   input  wire logic        pll_lock_in,
   input  wire logic        fabric_clk_in,
   input  wire logic        fabric_clk_ready,
   input  wire logic        ext_slow_clk_in,
   input  wire logic        stop_mode,
   output logic             internal_fast_osc_on,
   output logic             fast_ext_osc_on,
   output logic             pll_enable,
   output logic             slow_ext_osc_on,
   output logic             fast_ext_ready,
   output logic             slow_ext_ready,
   output logic             system_clock_out,
   output logic             fast_ext_clock_out,
   output logic             usb_48m_clock,
   output logic             watchdog_clock_out,
   output logic             calendar_kernel_clock
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic            int_en;
      logic            ext_en;
      logic            ext_byp;
      logic            pll_en;
      logic            sext_en;
      logic            sext_byp;
      logic [1:0]      req_src;
      logic [1:0]      act_src;
      logic [1:0]      cal_sel;
      ccs_pkg::ccs_sw_t sw;
      logic            s_int;
      logic            s_ext;
      logic            s_pll;
      logic            s_fab;
      logic            s_sext;
      logic            sys_clk;
      logic            ext_clk;
      logic            usb_clk;
      logic            cal_clk;
      logic            osc_int_on;
      logic            osc_ext_on;
      logic            osc_sext_on;
      logic            pready;
      logic            pslverr;
      logic [31:0]     prdata;
   } ccs_main_st_t;

   ccs_main_st_t q;
   ccs_main_st_t next_q;

   logic int_rdy;
   logic ext_rdy;
   logic sext_rdy;
   logic pll_rdy;
   logic slow_int_clk;

   // -----------------------------------------------------------------
   // oscillator readiness and slow internal divider
   // -----------------------------------------------------------------
   // each oscillator has its own timer, so one can stop without touching others
   ccs_osc_ready #(.STARTUP_CYCLES(INT_START)) u_int_rdy (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (q.int_en),
      .ready   (int_rdy)
   );

   // ready set by hardware after the startup delay
   ccs_osc_ready #(.STARTUP_CYCLES(EXT_START)) u_ext_rdy (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (q.ext_en),
      .ready   (ext_rdy)
   );

   // backup-domain oscillator timer
   ccs_osc_ready #(.STARTUP_CYCLES(SEXT_START)) u_sext_rdy (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (q.sext_en),
      .ready   (sext_rdy)
   );

   // divider ignores stop_mode so the watchdog keeps its clock
   ccs_clk_div #(.DIV(SLOW_DIV)) u_slow_div (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (int_rdy),
      .clk_level (q.s_int),
      .div_clk   (slow_int_clk)
   );

   // pll counts as ready only when its reference is ready too
   assign pll_rdy = q.pll_en & pll_lock_in & ext_rdy;

   // -----------------------------------------------------------------
   // source helpers
   // -----------------------------------------------------------------
   // sampled level of a source
   function automatic logic src_level(input logic [1:0] src,
                                      input ccs_main_st_t s);
      logic r;
      r = s.s_int;
      unique case (src)
         ccs_pkg::CCS_SRC_INT: r = s.s_int;
         ccs_pkg::CCS_SRC_EXT: r = s.s_ext;
         ccs_pkg::CCS_SRC_PLL: r = s.s_pll;
         ccs_pkg::CCS_SRC_FAB: r = s.s_fab;
      endcase
      return r;
   endfunction

   // readiness of a source
   function automatic logic src_ready(input logic [1:0] src,
                                      input logic       r_int,
                                      input logic       r_ext,
                                      input logic       r_pll,
                                      input logic       r_fab);
      logic r;
      r = r_int;
      unique case (src)
         ccs_pkg::CCS_SRC_INT: r = r_int;
         ccs_pkg::CCS_SRC_EXT: r = r_ext;
         ccs_pkg::CCS_SRC_PLL: r = r_pll;
         ccs_pkg::CCS_SRC_FAB: r = r_fab;
      endcase
      return r;
   endfunction

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   logic [31:0] ctrl_rd;
   logic [31:0] cfg_rd;
   logic [31:0] bkp_rd;
   logic [31:0] wv;
   logic        wr_en;
   logic        tgt_rdy;

   // read views of the three registers
   always_comb begin
      ctrl_rd = '0;
      ctrl_rd[ccs_pkg::CCS_B_INT_EN]  = q.int_en;
      ctrl_rd[ccs_pkg::CCS_B_INT_RDY] = int_rdy;
      ctrl_rd[ccs_pkg::CCS_B_EXT_EN]  = q.ext_en;
      ctrl_rd[ccs_pkg::CCS_B_EXT_RDY] = ext_rdy;
      ctrl_rd[ccs_pkg::CCS_B_EXT_BYP] = q.ext_byp;
      ctrl_rd[ccs_pkg::CCS_B_PLL_EN]  = q.pll_en;
      ctrl_rd[ccs_pkg::CCS_B_PLL_RDY] = pll_rdy;
      cfg_rd = '0;
      cfg_rd[ccs_pkg::CCS_F_REQ +: 2] = q.req_src;
      cfg_rd[ccs_pkg::CCS_F_ACT +: 2] = q.act_src;
      cfg_rd[ccs_pkg::CCS_B_PEND]     = (q.sw != ccs_pkg::CCS_SW_IDLE);
      bkp_rd = '0;
      bkp_rd[ccs_pkg::CCS_B_SEXT_EN]  = q.sext_en;
      bkp_rd[ccs_pkg::CCS_B_SEXT_RDY] = sext_rdy;
      bkp_rd[ccs_pkg::CCS_B_SEXT_BYP] = q.sext_byp;
      bkp_rd[ccs_pkg::CCS_F_CAL +: 2] = q.cal_sel;
   end

   always_comb begin
      next_q = q;
      wv     = '0;
      wr_en  = psel & penable & q.pready & pwrite & ~q.pslverr;
      tgt_rdy = src_ready(q.req_src, int_rdy, ext_rdy, pll_rdy, fabric_clk_ready);

      // inputs are synchronous, one sample flop each
      next_q.s_int  = int_fast_clk_in;
      next_q.s_ext  = ext_fast_clk_in;
      next_q.s_pll  = pll_clk_in;
      next_q.s_fab  = fabric_clk_in;
      next_q.s_sext = ext_slow_clk_in;

      // apb answer registered in setup, shown during access
      next_q.pready  = psel & ~penable;
      next_q.pslverr = 1'b0;
      if (psel & ~penable) begin
         unique case (paddr)
            ccs_pkg::CCS_OFF_CTRL: next_q.prdata = ctrl_rd;
            ccs_pkg::CCS_OFF_CFG:  next_q.prdata = cfg_rd;
            ccs_pkg::CCS_OFF_BKP:  next_q.prdata = bkp_rd;
            default: begin
               next_q.prdata  = '0;
               next_q.pslverr = 1'b1;
            end
         endcase
      end

      // register writes; enables of the feeding source are forced on
      if (wr_en) begin
         unique case (paddr)
            ccs_pkg::CCS_OFF_CTRL: begin
               wv = ccs_pkg::ccs_merge(ctrl_rd, pwdata, pstrb);
               next_q.int_en  = wv[ccs_pkg::CCS_B_INT_EN]
                              | (q.act_src == ccs_pkg::CCS_SRC_INT);
               next_q.ext_en  = wv[ccs_pkg::CCS_B_EXT_EN]
                              | (q.act_src == ccs_pkg::CCS_SRC_EXT)
                              | (q.act_src == ccs_pkg::CCS_SRC_PLL);
               next_q.pll_en  = wv[ccs_pkg::CCS_B_PLL_EN]
                              | (q.act_src == ccs_pkg::CCS_SRC_PLL);
               next_q.ext_byp = wv[ccs_pkg::CCS_B_EXT_BYP];
            end
            ccs_pkg::CCS_OFF_CFG: begin
               wv = ccs_pkg::ccs_merge(cfg_rd, pwdata, pstrb);
               next_q.req_src = wv[ccs_pkg::CCS_F_REQ +: 2];
            end
            ccs_pkg::CCS_OFF_BKP: begin
               wv = ccs_pkg::ccs_merge(bkp_rd, pwdata, pstrb);
               next_q.sext_en  = wv[ccs_pkg::CCS_B_SEXT_EN];
               next_q.sext_byp = wv[ccs_pkg::CCS_B_SEXT_BYP];
               next_q.cal_sel  = wv[ccs_pkg::CCS_F_CAL +: 2];
            end
            default: begin
            end
         endcase
      end

      // switch waits for ready, then for both levels low
      unique case (q.sw)
         ccs_pkg::CCS_SW_IDLE: begin
            if (q.req_src != q.act_src) begin
               next_q.sw = ccs_pkg::CCS_SW_WAIT_RDY;
            end
         end
         ccs_pkg::CCS_SW_WAIT_RDY: begin
            if (q.req_src == q.act_src) begin
               next_q.sw = ccs_pkg::CCS_SW_IDLE;
            end else if (tgt_rdy) begin
               next_q.sw = ccs_pkg::CCS_SW_WAIT_LOW;
            end
         end
         ccs_pkg::CCS_SW_WAIT_LOW: begin
            if (q.req_src == q.act_src) begin
               next_q.sw = ccs_pkg::CCS_SW_IDLE;
            end else if (!tgt_rdy) begin
               next_q.sw = ccs_pkg::CCS_SW_WAIT_RDY;
            end else if (!src_level(q.act_src, q) && !src_level(q.req_src, q)) begin
               next_q.act_src = q.req_src;
               next_q.sw      = ccs_pkg::CCS_SW_IDLE;
            end
         end
         default: begin
            next_q.sw = ccs_pkg::CCS_SW_IDLE;
         end
      endcase

      // old source keeps driving until the swap in a common low phase
      next_q.sys_clk = ~stop_mode & src_level(q.act_src, q);
      next_q.ext_clk = q.s_ext & ext_rdy;
      next_q.usb_clk = q.s_pll & pll_rdy;
      next_q.cal_clk = (q.cal_sel == ccs_pkg::CCS_CAL_SLOW_EXT)
                     ? (q.s_sext & sext_rdy)
                     : slow_int_clk;

      // crystal amplifiers are off in bypass; the pin is then driven outside
      next_q.osc_int_on  = q.int_en;
      next_q.osc_ext_on  = q.ext_en & ~q.ext_byp;
      next_q.osc_sext_on = q.sext_en & ~q.sext_byp;
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   // reset puts the fast internal oscillator on the system clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q         <= '0;
         q.int_en  <= ccs_pkg::CCS_RST_INT_EN;
         q.req_src <= ccs_pkg::CCS_SRC_INT;
         q.act_src <= ccs_pkg::CCS_SRC_INT;
         q.sw      <= ccs_pkg::CCS_SW_IDLE;
      end else begin
         q <= next_q;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // every output is a flop of the state or of a submodule
   assign prdata                = q.prdata;
   assign pready                = q.pready;
   assign pslverr               = q.pslverr;
   assign internal_fast_osc_on  = q.osc_int_on;
   assign fast_ext_osc_on       = q.osc_ext_on;
   assign pll_enable            = q.pll_en;
   assign slow_ext_osc_on       = q.osc_sext_on;
   assign fast_ext_ready        = ext_rdy;
   assign slow_ext_ready        = sext_rdy;
   assign system_clock_out      = q.sys_clk;
   assign fast_ext_clock_out    = q.ext_clk;
   assign usb_48m_clock         = q.usb_clk;
   assign watchdog_clock_out    = slow_int_clk;
   assign calendar_kernel_clock = q.cal_clk;

endmodule // ccs_clock_ctrl

// File: sim/ccs_clock_ctrl_monitor.sv
// Purpose: port-level assertions for the clock source control block
// Assumes: single pclk domain, async active-low reset
// Notes:   watchdog ratio counted on sampled internal clock rises
`timescale 1ns/1ps
module ccs_clock_ctrl_monitor #(
   parameter int SLOW_DIV = 256
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        int_fast_clk_in,
   input wire logic        internal_fast_osc_on,
   input wire logic        stop_mode,
   input wire logic        pll_enable,
   input wire logic        fast_ext_ready,
   input wire logic        system_clock_out,
   input wire logic        fast_ext_clock_out,
   input wire logic        usb_48m_clock,
   input wire logic        watchdog_clock_out
);
   logic [15:0] n_rise;
   logic        seen;
   logic        int_q;
   logic        wd_q;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // rises of the internal clock between two watchdog edges
   // a disabled internal oscillator parks the divider, so restart the count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_rise <= '0;
         seen   <= 1'b0;
         int_q  <= 1'b0;
         wd_q   <= 1'b0;
      end else begin
         int_q <= int_fast_clk_in;
         wd_q  <= watchdog_clock_out;
         if (!internal_fast_osc_on) begin
            seen <= 1'b0;
         end else if (wd_q != watchdog_clock_out) begin
            seen   <= 1'b1;
            n_rise <= {15'b0, int_fast_clk_in & ~int_q};
         end else if (int_fast_clk_in & ~int_q) begin
            n_rise <= n_rise + 16'h0001;
         end
      end
   end

   a_access_follows: assert property (psel && !penable |=> pready)
      else $error("setup not answered next cycle");
   a_ready_cause: assert property (pready |-> $past(psel && !penable))
      else $error("pready without setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("bad error response");
   a_ext_gated: assert property (fast_ext_clock_out |-> $past(fast_ext_ready))
      else $error("fast external clock before ready");
   a_usb_gated: assert property (usb_48m_clock |-> $past(pll_enable && fast_ext_ready))
      else $error("usb clock without ready pll");
   a_stop_quiet: assert property (stop_mode [*2] |=> !system_clock_out)
      else $error("system clock runs in stop");
   a_wdog_ratio: assert property (seen && wd_q != watchdog_clock_out |->
         n_rise == 16'(SLOW_DIV / 2))
      else $error("watchdog clock ratio wrong");
endmodule // ccs_clock_ctrl_monitor

bind ccs_clock_ctrl ccs_clock_ctrl_monitor #(.SLOW_DIV(SLOW_DIV)) i_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .int_fast_clk_in(int_fast_clk_in), .internal_fast_osc_on(internal_fast_osc_on),
   .stop_mode(stop_mode),
   .pll_enable(pll_enable), .fast_ext_ready(fast_ext_ready),
   .system_clock_out(system_clock_out), .fast_ext_clock_out(fast_ext_clock_out),
   .usb_48m_clock(usb_48m_clock), .watchdog_clock_out(watchdog_clock_out));

// File: sim/ccs_osc_model.sv
// Purpose: crystals, bypass drivers and pll at the oscillator pins
// Assumes: clock periods of 10, 12 and 14 pclk, all slow against pclk
// Notes:   a stopped oscillator holds its pin low; periods differ to drift phase
`timescale 1ns/1ps
module ccs_osc_model (
   input  wire logic pclk,
   input  wire logic fast_on,
   input  wire logic fast_byp,
   input  wire logic slow_on,
   input  wire logic slow_byp,
   input  wire logic pll_on,
   output logic      ext_fast,
   output logic      ext_slow,
   output logic      pll_clk,
   output logic      pll_lock
);
   logic [7:0] c  = '0;
   logic [3:0] lk = '0;

   // free phase counter and pll lock delay
   always_ff @(posedge pclk) begin
      c  <= c + 8'h01;
      lk <= !pll_on ? 4'h0 : (lk == 4'h6) ? lk : lk + 4'h1;
   end

   // bypass drivers keep the pin running with the amplifier off
   assign ext_fast = (fast_on | fast_byp) & (c % 10 < 5);
   assign ext_slow = (slow_on | slow_byp) & (c % 14 < 7);
   assign pll_lock = lk == 4'h6;
   assign pll_clk  = pll_lock & (c % 12 < 6);
endmodule // ccs_osc_model

// File: sim/ccs_clock_ctrl_tb_top.sv
// Purpose: register-level test of the clock source control block
// Assumes: short startup counts and divide by 4 to keep the run brief
// Notes:   one idle cycle between apb transfers, two after a write
`timescale 1ns/1ps
module ccs_clock_ctrl_tb_top;
   localparam logic [11:0] CTRL = ccs_pkg::CCS_OFF_CTRL;
   localparam logic [11:0] CFG  = ccs_pkg::CCS_OFF_CFG;
   localparam logic [11:0] BKP  = ccs_pkg::CCS_OFF_BKP;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [3:0]  pstrb, tc;
   logic        int_clk, fab_clk, fab_rdy, stop_mode, byp_f, byp_s;
   logic        ext_f, ext_s, pll_clk, pll_lock, int_on, ext_on, pll_en, sext_on;
   logic        ext_rdy, sext_rdy, sys_clk, ext_clk, usb_clk, wd_clk, cal_clk;
   int          errors, n_compared, n_sys, n_wd, n_cal, n_usb, s0, s1;

   ccs_clock_ctrl #(.INT_START(4), .EXT_START(8), .SEXT_START(8), .SLOW_DIV(4)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .int_fast_clk_in(int_clk), .ext_fast_clk_in(ext_f),
      .pll_clk_in(pll_clk), .pll_lock_in(pll_lock), .fabric_clk_in(fab_clk),
      .fabric_clk_ready(fab_rdy), .ext_slow_clk_in(ext_s), .stop_mode(stop_mode),
      .internal_fast_osc_on(int_on), .fast_ext_osc_on(ext_on), .pll_enable(pll_en),
      .slow_ext_osc_on(sext_on), .fast_ext_ready(ext_rdy), .slow_ext_ready(sext_rdy),
      .system_clock_out(sys_clk), .fast_ext_clock_out(ext_clk), .usb_48m_clock(usb_clk),
      .watchdog_clock_out(wd_clk), .calendar_kernel_clock(cal_clk));

   ccs_osc_model i_osc (.pclk(pclk), .fast_on(ext_on), .fast_byp(byp_f),
      .slow_on(sext_on), .slow_byp(byp_s), .pll_on(pll_en), .ext_fast(ext_f),
      .ext_slow(ext_s), .pll_clk(pll_clk), .pll_lock(pll_lock));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // internal oscillator runs only while enabled; fabric clock is free
   always @(posedge pclk) begin
      tc      <= tc + 4'h1;
      int_clk <= int_on & tc[2];
      fab_clk <= tc[3];
   end

   // activity counters on the clock outputs
   always @(sys_clk) n_sys++;
   always @(wd_clk) n_wd++;
   always @(cal_clk) n_cal++;
   always @(usb_clk) n_usb++;

   task automatic results();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // one apb transfer; waits for pready under a bound
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      int k;
      k = 0;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) errors++;
      rd      = prdata;
      slv     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // one extra edge so registered pin outputs of the write have settled
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      xfer(1'b1, a, v, d);
      @(posedge pclk);
   endtask

   // repeated reads until the masked value appears
   task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      int k;
      k = 0;
      do begin
         xfer(1'b0, a, 32'h0, d);
         k++;
      end while ((d & m) !== e && k < 100);
      chk(d & m, e);
   endtask

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, tc} = '0;
      {int_clk, fab_clk, fab_rdy, stop_mode, byp_f, byp_s} = '0;
      pstrb = 4'hf;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      poll(CTRL, 32'hffff_ffff, 32'h0000_0003);
      poll(CFG, 32'hffff_ffff, 32'h0000_0000);
      xfer(1'b0, 12'h00c, 32'h0, d);
      chk({d[30:0], slv}, 32'h0000_0001);
      wr(CTRL, 32'h0000_0000);
      poll(CTRL, 32'hffff_ffff, 32'h0000_0003);
      wr(CFG, 32'h0000_0001);
      poll(CFG, 32'h0000_001f, 32'h0000_0011);
      s0 = n_sys;
      wr(CTRL, 32'h0001_0001);
      chk({31'b0, ext_on}, 32'h1);
      poll(CFG, 32'h0000_001f, 32'h0000_0005);
      chk(32'(n_sys > s0), 32'h1);
      wr(CTRL, 32'h0000_0001);
      poll(CTRL, 32'hffff_ffff, 32'h0003_0003);
      wr(CTRL, 32'h0001_0000);
      poll(CTRL, 32'hffff_ffff, 32'h0003_0000);
      byp_f <= 1'b1;
      wr(CTRL, 32'h0105_0001);
      chk({31'b0, ext_on}, 32'h0);
      poll(CTRL, 32'hffff_ffff, 32'h0307_0003);
      wr(CFG, 32'h0000_0002);
      poll(CFG, 32'h0000_001f, 32'h0000_000a);
      chk(32'(n_usb > 0), 32'h1);
      wr(CTRL, 32'h0100_0001);
      poll(CTRL, 32'hffff_ffff, 32'h0303_0003);
      wr(CFG, 32'h0000_0003);
      poll(CFG, 32'h0000_001f, 32'h0000_001b);
      fab_rdy <= 1'b1;
      poll(CFG, 32'h0000_001f, 32'h0000_000f);
      wr(BKP, 32'h0000_0101);
      poll(BKP, 32'hffff_ffff, 32'h0000_0103);
      chk({30'b0, sext_rdy, int_on}, 32'h0000_0003);
      s0 = n_cal;
      repeat (60) @(posedge pclk);
      chk(32'(n_cal > s0), 32'h1);
      byp_s <= 1'b1;
      wr(BKP, 32'h0000_0105);
      chk({31'b0, sext_on}, 32'h0);
      stop_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      s0 = n_sys;
      s1 = n_wd;
      repeat (64) @(posedge pclk);
      chk({31'b0, sys_clk}, 32'h0);
      chk(32'(n_wd > s1 && n_sys == s0), 32'h1);
      stop_mode <= 1'b0;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      poll(CFG, 32'hffff_ffff, 32'h0000_0000);
      results();
   end

   // hang guard, well beyond the few hundred cycles the tests need
   initial begin
      #400us;
      errors++;
      results();
   end
endmodule // ccs_clock_ctrl_tb_top
